//--- tfg_pkg.sv
// Constants, register map and types of the tone, ring and FSK generator
package tfg_pkg;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 50;
	localparam int SAMPLE_DIV = 833;
	localparam int BIT_TIME_NS = 833_000;
	localparam int BIT_CYCLES = BIT_TIME_NS / CLK_PERIOD_NS;
	localparam int SAMPLES_PER_BIT = BIT_CYCLES / SAMPLE_DIV;
	localparam int MS_TIME_NS = 1_000_000;
	localparam int MS_SAMPLES = (MS_TIME_NS / CLK_PERIOD_NS) / SAMPLE_DIV;
	// ----------------------------------------
	// Register word addresses
	// ----------------------------------------
	localparam logic [4:0] A_CTRL = 5'h00;
	localparam logic [4:0] A_LINE = 5'h01;
	localparam logic [4:0] A_STAT = 5'h02;
	localparam logic [4:0] A_BIAS = 5'h03;
	localparam logic [4:0] A_FREQ = 5'h04;
	localparam logic [4:0] A_AMP = 5'h08;
	localparam logic [4:0] A_RAMP = 5'h0C;
	localparam logic [4:0] A_CID = 5'h10;
	localparam logic [4:0] A_CADA = 5'h11;
	localparam logic [4:0] A_CADD = 5'h12;
	// ----------------------------------------
	// Fields and reset values
	// ----------------------------------------
	localparam int F_BIAS_EN = 4;
	localparam int F_TRAP = 5;
	localparam int F_FRAME = 6;
	localparam int F_CAD_GO = 7;
	localparam int F_CID_GO = 8;
	localparam logic [15:0] FSK_AMP_RST = 16'h2000;
	localparam logic [15:0] AMP_RST = 16'h0000;
	localparam logic [2:0] LS_RING = 3'h6;
	localparam logic [2:0] LS_RING_REV = 3'h7;
	localparam int CID_DEPTH = 32;
	localparam int CID_REFILL = 16;
	localparam int CAD_DEPTH = 16;
	localparam logic [15:0] SAT_POS = 16'h7FFF;
	localparam logic [15:0] SAT_NEG = 16'h8000;
	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [3:0] {
		OP_END = 4'h0, OP_TIME = 4'h1, OP_GEN = 4'h2, OP_BRANCH = 4'h3,
		OP_LINE = 4'h4, OP_CID = 4'h5, OP_CID_WAIT = 4'h6
	} tfg_op_t;
	typedef enum logic [1:0] {
		CAD_IDLE = 2'b00, CAD_EXEC = 2'b01, CAD_TIME = 2'b10, CAD_CIDW = 2'b11
	} tfg_cad_t;
	typedef struct packed {
		logic [4:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} tfg_req_t;
endpackage

//--- tfg_gen.sv
// Signal generators, bias, caller ID engine, cadencer and register port
`timescale 1ns/1ps
`default_nettype none
module tfg_gen (
	input wire logic mclk,
	input wire logic nrst,
	input wire tfg_pkg::tfg_req_t req,
	output logic [15:0] reg_rdata,
	output logic [15:0] sample_out,
	output logic sample_strobe,
	output logic [2:0] line_state,
	output logic cid_data_request_event
);
	import tfg_pkg::*;

	// ----------------------------------------
	// Sample rate divider
	// ----------------------------------------
	logic [9:0] div_reg;
	logic tick;
	assign tick = (div_reg == 10'(SAMPLE_DIV - 1));
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			div_reg <= 10'h000;
		end else begin
			div_reg <= tick ? 10'h000 : div_reg + 10'h001;
		end
	end

	// ----------------------------------------
	// Control registers
	// ----------------------------------------
	logic [3:0] gen_en_reg;
	logic bias_en_reg, trap_reg, frame_reg;
	logic [15:0] bias_reg;
	logic [2:0] line_reg;
	logic [3:0] cad_addr_reg;
	logic [15:0] cad_mem [CAD_DEPTH];
	logic ringing, cad_gen_wr, cad_line_wr;
	logic [15:0] cad_word;
	assign ringing = (line_reg == LS_RING) || (line_reg == LS_RING_REV);
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			gen_en_reg <= 4'h0;
			bias_en_reg <= 1'b0;
			trap_reg <= 1'b0;
			frame_reg <= 1'b0;
			bias_reg <= 16'h0000;
		end else if (req.wr && req.addr == A_CTRL) begin
			gen_en_reg <= req.wdata[3:0];
			bias_en_reg <= req.wdata[F_BIAS_EN];
			trap_reg <= req.wdata[F_TRAP];
			frame_reg <= req.wdata[F_FRAME];
		end else if (cad_gen_wr) begin
			gen_en_reg <= cad_word[3:0];
		end else if (req.wr && req.addr == A_BIAS) begin
			bias_reg <= req.wdata;
		end
	end
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			line_reg <= 3'h0;
		end else if (req.wr && req.addr == A_LINE) begin
			line_reg <= req.wdata[2:0];
		end else if (cad_line_wr) begin
			line_reg <= cad_word[2:0];
		end
	end
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			cad_addr_reg <= 4'h0;
		end else if (req.wr && req.addr == A_CADA) begin
			cad_addr_reg <= req.wdata[3:0];
		end else if (req.wr && req.addr == A_CADD) begin
			cad_addr_reg <= cad_addr_reg + 4'h1;
		end
	end
	// Program store has no reset; the host loads it before starting
	always_ff @(posedge mclk) begin
		if (req.wr && req.addr == A_CADD) begin
			cad_mem[cad_addr_reg] <= req.wdata;
		end
	end
	assign line_state = line_reg;

	// ----------------------------------------
	// Caller ID byte store
	// ----------------------------------------
	logic [7:0] cid_mem [CID_DEPTH];
	logic [4:0] cid_wp_reg, cid_rp_reg;
	logic [5:0] cid_cnt_reg;
	logic cid_push, cid_pop, cid_busy_reg, cid_start;
	logic [9:0] cid_sh_reg;
	logic [3:0] cid_bits_reg;
	logic [4:0] cid_smp_reg;
	logic cid_bit;
	// Writes beyond the store depth are dropped
	assign cid_push = req.wr && req.addr == A_CID && cid_cnt_reg != 6'(CID_DEPTH);
	always_ff @(posedge mclk) begin
		if (cid_push) begin
			cid_mem[cid_wp_reg] <= req.wdata[7:0];
		end
	end
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			cid_wp_reg <= 5'h00;
			cid_rp_reg <= 5'h00;
			cid_cnt_reg <= 6'h00;
		end else begin
			cid_wp_reg <= cid_wp_reg + 5'(cid_push);
			cid_rp_reg <= cid_rp_reg + 5'(cid_pop);
			cid_cnt_reg <= cid_cnt_reg + 6'(cid_push) - 6'(cid_pop);
		end
	end
	// Request fires once as the store drains to room for a full refill
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			cid_data_request_event <= 1'b0;
		end else begin
			cid_data_request_event <= cid_busy_reg && cid_pop && !cid_push
				&& cid_cnt_reg == 6'(CID_REFILL + 1);
		end
	end

	// ----------------------------------------
	// FSK bit timer and serialiser
	// ----------------------------------------
	logic bit_end;
	assign bit_end = tick && cid_smp_reg == 5'(SAMPLES_PER_BIT - 1);
	assign cid_pop = cid_busy_reg && bit_end && cid_bits_reg == 4'h0
		&& cid_cnt_reg != 6'h00;
	assign cid_bit = cid_sh_reg[0];
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			cid_smp_reg <= 5'h00;
		end else if (!cid_busy_reg) begin
			cid_smp_reg <= 5'h00;
		end else if (tick) begin
			cid_smp_reg <= bit_end ? 5'h00 : cid_smp_reg + 5'h01;
		end
	end
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			cid_busy_reg <= 1'b0;
			cid_sh_reg <= 10'h3FF;
			cid_bits_reg <= 4'h0;
		end else if (!cid_busy_reg) begin
			cid_busy_reg <= cid_start;
			cid_sh_reg <= 10'h3FF;
			cid_bits_reg <= 4'h0;
		end else if (bit_end) begin
			if (cid_bits_reg != 4'h0) begin
				cid_sh_reg <= {1'b1, cid_sh_reg[9:1]};
				cid_bits_reg <= cid_bits_reg - 4'h1;
			end else if (cid_cnt_reg != 6'h00) begin
				// Framed bytes carry start and stop bits, raw bytes do not
				if (frame_reg) begin
					cid_sh_reg <= {1'b1, cid_mem[cid_rp_reg], 1'b0};
					cid_bits_reg <= 4'h9;
				end else begin
					cid_sh_reg <= {2'b11, cid_mem[cid_rp_reg]};
					cid_bits_reg <= 4'h7;
				end
			end else begin
				cid_busy_reg <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Cadence sequencer
	// ----------------------------------------
	tfg_cad_t cad_state;
	logic [3:0] cad_pc_reg;
	logic [7:0] cad_rep_reg;
	logic [11:0] cad_tmr_reg;
	logic [4:0] cad_ms_reg;
	logic cad_cid_go, cad_go;
	tfg_op_t op;
	assign cad_word = cad_mem[cad_pc_reg];
	assign op = tfg_op_t'(cad_word[15:12]);
	assign cad_go = req.wr && req.addr == A_CTRL && req.wdata[F_CAD_GO];
	assign cad_gen_wr = cad_state == CAD_EXEC && op == OP_GEN;
	assign cad_line_wr = cad_state == CAD_EXEC && op == OP_LINE;
	assign cad_cid_go = cad_state == CAD_EXEC
		&& (op == OP_CID || op == OP_CID_WAIT);
	assign cid_start = cad_cid_go
		|| (req.wr && req.addr == A_CTRL && req.wdata[F_CID_GO]);
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			cad_state <= CAD_IDLE;
			cad_pc_reg <= 4'h0;
			cad_rep_reg <= 8'h00;
			cad_tmr_reg <= 12'h000;
			cad_ms_reg <= 5'h00;
		end else begin
			unique case (cad_state)
				CAD_IDLE: begin
					cad_pc_reg <= 4'h0;
					cad_rep_reg <= 8'h00;
					if (cad_go) begin
						cad_state <= CAD_EXEC;
					end
				end
				CAD_EXEC: begin
					cad_pc_reg <= cad_pc_reg + 4'h1;
					case (op)
						OP_TIME: begin
							cad_tmr_reg <= cad_word[11:0];
							cad_ms_reg <= 5'h00;
							cad_state <= CAD_TIME;
						end
						OP_BRANCH: begin
							// Zero count loops forever
							if (cad_word[7:0] == 8'h00
								|| cad_rep_reg != cad_word[7:0]) begin
								cad_pc_reg <= cad_word[11:8];
								cad_rep_reg <= cad_rep_reg + 8'h01;
							end else begin
								cad_rep_reg <= 8'h00;
							end
						end
						OP_CID_WAIT: begin
							cad_state <= CAD_CIDW;
						end
						OP_GEN, OP_LINE, OP_CID: begin
						end
						default: begin
							cad_state <= CAD_IDLE;
						end
					endcase
				end
				CAD_TIME: begin
					// Delay counts milliseconds; other logic keeps running
					if (cad_tmr_reg == 12'h000) begin
						cad_state <= CAD_EXEC;
					end else if (tick) begin
						if (cad_ms_reg == 5'(MS_SAMPLES - 1)) begin
							cad_ms_reg <= 5'h00;
							cad_tmr_reg <= cad_tmr_reg - 12'h001;
						end else begin
							cad_ms_reg <= cad_ms_reg + 5'h01;
						end
					end
				end
				CAD_CIDW: begin
					if (!cid_busy_reg && !cid_start) begin
						cad_state <= CAD_EXEC;
					end
				end
			endcase
		end
	end

	// ----------------------------------------
	// Tone generators
	// ----------------------------------------
	logic signed [15:0] gen_out [4];
	logic [15:0] amp_w [4];
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : gen_tone
			logic [15:0] freq_reg, amp_reg, ramp_reg, phase_reg, inc;
			logic [13:0] fold;
			logic signed [16:0] tri_w;
			logic signed [33:0] prod;
			always_ff @(posedge mclk or negedge nrst) begin
				if (!nrst) begin
					freq_reg <= 16'h0000;
					amp_reg <= (g >= 2) ? FSK_AMP_RST : AMP_RST;
					ramp_reg <= 16'h0000;
				end else if (req.wr && req.addr == A_FREQ + 5'(g)) begin
					freq_reg <= req.wdata;
				end else if (req.wr && req.addr == A_AMP + 5'(g)) begin
					amp_reg <= req.wdata;
				end else if (req.wr && req.addr == A_RAMP + 5'(g)) begin
					ramp_reg <= req.wdata;
				end else if (tick) begin
					// Signed steps each sample give ramps and howler sweeps
					freq_reg <= freq_reg + {{8{ramp_reg[15]}}, ramp_reg[15:8]};
					amp_reg <= amp_reg + {{8{ramp_reg[7]}}, ramp_reg[7:0]};
				end
			end
			// Generator C takes D's step on space bits so phase never jumps
			if (g == 2) begin : g_fsk
				assign inc = (cid_busy_reg && !cid_bit) ? gen_tone[3].freq_reg
					: freq_reg;
			end else begin : g_plain
				assign inc = freq_reg;
			end
			always_ff @(posedge mclk or negedge nrst) begin
				if (!nrst) begin
					phase_reg <= 16'h0000;
				end else if (tick) begin
					phase_reg <= phase_reg + inc;
				end
			end
			assign fold = phase_reg[14] ? ~phase_reg[13:0] : phase_reg[13:0];
			assign tri_w = phase_reg[15] ? -$signed({2'b00, fold, 1'b0})
				: $signed({2'b00, fold, 1'b0});
			assign prod = tri_w * $signed({1'b0, amp_reg});
			assign gen_out[g] = 16'(prod >>> 15);
			assign amp_w[g] = amp_reg;
		end
	endgenerate

	// ----------------------------------------
	// Summation and output
	// ----------------------------------------
	logic [3:0] en_eff;
	logic signed [15:0] a_shaped, clip;
	logic signed [18:0] sum;
	logic bias_on;
	assign clip = $signed({1'b0, amp_w[1][15:1]});
	// Trapezoid: A is flattened at half the level held in B's amplitude
	assign a_shaped = (trap_reg && ringing) ? ((gen_out[0] > clip) ? clip
		: (gen_out[0] < -clip) ? -clip : gen_out[0]) : gen_out[0];
	assign en_eff[0] = gen_en_reg[0] || ringing;
	assign en_eff[1] = gen_en_reg[1] && !(trap_reg && ringing);
	assign en_eff[2] = gen_en_reg[2] || cid_busy_reg;
	assign en_eff[3] = gen_en_reg[3] && !cid_busy_reg;
	assign bias_on = bias_en_reg || ringing;
	always_comb begin
		sum = bias_on ? 19'(signed'(bias_reg)) : 19'sd0;
		sum = sum + (en_eff[0] ? 19'(a_shaped) : 19'sd0);
		for (int i = 1; i < 4; i++) begin
			sum = sum + (en_eff[i] ? 19'(gen_out[i]) : 19'sd0);
		end
	end
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			sample_out <= 16'h0000;
			sample_strobe <= 1'b0;
		end else begin
			sample_strobe <= tick;
			if (tick) begin
				sample_out <= (sum > 19'sd32767) ? SAT_POS
					: (sum < -19'sd32768) ? SAT_NEG : 16'(sum);
			end
		end
	end

	// ----------------------------------------
	// Register read port
	// ----------------------------------------
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			reg_rdata <= 16'h0000;
		end else if (req.rd) begin
			if (req.addr == A_CTRL) begin
				reg_rdata <= {9'h000, frame_reg, trap_reg, bias_en_reg, gen_en_reg};
			end else if (req.addr == A_LINE) begin
				reg_rdata <= {13'h0000, line_reg};
			end else if (req.addr == A_STAT) begin
				reg_rdata <= {8'h00, cid_cnt_reg, cid_busy_reg, cad_state != CAD_IDLE};
			end else if (req.addr == A_BIAS) begin
				reg_rdata <= bias_reg;
			end else if (req.addr >= A_AMP && req.addr < A_RAMP) begin
				reg_rdata <= amp_w[req.addr[1:0]];
			end else begin
				reg_rdata <= 16'h0000;
			end
		end
	end
endmodule
`default_nettype wire

//--- tfg_gen_assertions.sv
// Concurrent port checks for the tone and FSK generator
`timescale 1ns/1ps
`default_nettype none
module tfg_gen_assertions (
	input wire logic mclk,
	input wire logic nrst,
	input wire tfg_pkg::tfg_req_t req,
	input wire logic [15:0] reg_rdata,
	input wire logic [15:0] sample_out,
	input wire logic sample_strobe,
	input wire logic [2:0] line_state,
	input wire logic cid_data_request_event
);
	import tfg_pkg::*;
	logic [9:0] gap_reg;
	logic seen_reg;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);
	// ----------------------------------------
	// Helper logic
	// ----------------------------------------
	// Counts clocks between ticks; an exact figure catches divider slips
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			gap_reg <= 10'h000;
			seen_reg <= 1'b0;
		end else begin
			gap_reg <= sample_strobe ? 10'h000 : gap_reg + 10'h001;
			seen_reg <= seen_reg | sample_strobe;
		end
	end
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	tick_period_a: assert property (sample_strobe && seen_reg |->
		gap_reg == 10'(SAMPLE_DIV - 1)) else $error("sample tick spacing");
	sample_hold_a: assert property ($changed(sample_out) |->
		sample_strobe) else $error("sample moved between ticks");
	cid_pulse_a: assert property (cid_data_request_event |=>
		!cid_data_request_event) else $error("data request too long");
	rdata_hold_a: assert property (!req.rd |=> $stable(reg_rdata))
		else $error("read data moved without read");
	unmapped_read_a: assert property (req.rd && req.addr > A_CADD |=>
		reg_rdata == 16'h0000) else $error("unmapped read not zero");
	line_write_a: assert property (req.wr && req.addr == A_LINE |=>
		line_state == $past(req.wdata[2:0])) else $error("line state write");
	cid_count_a: assert property (req.rd && req.addr == A_STAT |=>
		reg_rdata[7:2] <= 6'h20) else $error("byte count above limit");
	ctrl_pulse_a: assert property (req.rd && req.addr == A_CTRL |=>
		reg_rdata[8:7] == 2'b00) else $error("start bits read back");
	// ----------------------------------------
	// Coverage
	// ----------------------------------------
	cover property (sample_strobe && sample_out == SAT_POS);
	cover property (sample_strobe && line_state == LS_RING);
	cover property (req.rd && req.addr == A_STAT);
	cover property (cid_data_request_event);
endmodule
`default_nettype wire

//--- tfg_host.sv
// Host processor model driving the register port
`timescale 1ns/1ps
`default_nettype none
module tfg_host (
	input wire logic mclk,
	input wire logic [15:0] reg_rdata,
	output var tfg_pkg::tfg_req_t req
);
	import tfg_pkg::*;
	initial req = '0;
	// ----------------------------------------
	// Bus cycles
	// ----------------------------------------
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge mclk);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge mclk);
		req <= '0;
	endtask
	task automatic rd(input logic [4:0] a, output logic [15:0] d);
		@(posedge mclk);
		req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge mclk);
		req <= '0;
		@(posedge mclk);
		d = reg_rdata;
	endtask
	// Message bytes go in one per write; the count is the caller's choice
	task automatic cid_fill(input int n);
		for (int i = 0; i < n; i++) begin
			wr(A_CID, {8'h00, 8'h41 + 8'(i)});
		end
	endtask
endmodule
`default_nettype wire

//--- tfg_gen_tb.sv
// Self-checking testbench for the tone and FSK generator
`timescale 1ns/1ps
`default_nettype none
module tfg_gen_tb;
	import tfg_pkg::*;
	localparam logic [15:0] CAD_PROG [0:5] = '{16'h4006, 16'h2005,
		16'h1001, 16'h3101, 16'h4000, 16'h0000};
	logic mclk;
	logic nrst;
	tfg_req_t req;
	logic [15:0] reg_rdata;
	logic [15:0] sample_out;
	logic sample_strobe;
	logic [2:0] line_state;
	logic cid_data_request_event;
	int num_errors = 0;
	int tests_run = 0;
	tfg_gen dut (.mclk(mclk), .nrst(nrst), .req(req),
		.reg_rdata(reg_rdata), .sample_out(sample_out),
		.sample_strobe(sample_strobe), .line_state(line_state),
		.cid_data_request_event(cid_data_request_event));
	tfg_host u_host (.mclk(mclk), .reg_rdata(reg_rdata), .req(req));
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic check(input string n, input logic [15:0] seen,
		input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic rd_check(input string n, input logic [4:0] a,
		input logic [15:0] m, input logic [15:0] e);
		logic [15:0] v;
		u_host.rd(a, v);
		check(n, v & m, e);
	endtask
	// Bounded so a dead divider cannot hang the run
	task automatic wait_tick(input int n);
		int k;
		for (int i = 0; i < n; i++) begin
			k = 0;
			do begin
				@(posedge mclk);
				k++;
			end while (!sample_strobe && k < 900);
			check("tick", {15'h0000, k < 900}, 16'h0001);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_regs();
		for (int i = 0; i < 4; i++) begin
			rd_check("amp_rst", A_AMP + 5'(i), 16'hFFFF,
				i < 2 ? AMP_RST : FSK_AMP_RST);
		end
		rd_check("unmapped", 5'h1F, 16'hFFFF, 16'h0000);
		for (int i = 0; i < 4; i++) begin
			u_host.wr(A_AMP + 5'(i), 16'h1111 * 16'(i + 1));
		end
		for (int i = 0; i < 4; i++) begin
			rd_check("amp_own", A_AMP + 5'(i), 16'hFFFF,
				16'h1111 * 16'(i + 1));
		end
		// Start on a tick boundary so exactly two steps land; 0xFF steps down
		wait_tick(1);
		u_host.wr(A_RAMP, 16'h00FF);
		wait_tick(2);
		u_host.wr(A_RAMP, 16'h0000);
		rd_check("amp_ramp", A_AMP, 16'hFFFF, 16'h110F);
	endtask
	task automatic t_bias();
		u_host.wr(A_BIAS, 16'h1234);
		u_host.wr(A_AMP, 16'h0000);
		u_host.wr(A_CTRL, 16'(1 << F_BIAS_EN));
		wait_tick(2);
		check("bias", sample_out, 16'h1234);
		u_host.wr(A_CTRL, 16'h0000);
		wait_tick(2);
		check("bias_off", sample_out, 16'h0000);
		for (int i = 0; i < 2; i++) begin
			u_host.wr(A_LINE, {13'h0000, i ? LS_RING_REV : LS_RING});
			wait_tick(2);
			check("ring_bias", sample_out, 16'h1234);
		end
		u_host.wr(A_LINE, 16'h0000);
	endtask
	// A and C peaks stay below full scale, so only wrap can flip the sign
	task automatic t_sat();
		logic [15:0] b;
		int hits;
		u_host.wr(A_AMP, 16'h4000);
		u_host.wr(A_FREQ, 16'h2000);
		u_host.wr(A_FREQ + 5'h02, 16'h2000);
		u_host.wr(A_CTRL, 16'h0015);
		for (int s = 0; s < 2; s++) begin
			b = s ? SAT_NEG : SAT_POS;
			u_host.wr(A_BIAS, b);
			wait_tick(1);
			hits = 0;
			for (int k = 0; k < 12; k++) begin
				wait_tick(1);
				check("sat_sign", {15'h0000, sample_out[15]},
					{15'h0000, b[15]});
				if (sample_out === b) hits++;
			end
			check("sat_hit", {15'h0000, hits != 0}, 16'h0001);
		end
		u_host.wr(A_CTRL, 16'h0000);
	endtask
	task automatic t_cad();
		int n;
		u_host.wr(A_CADA, 16'h0000);
		for (int i = 0; i < 6; i++) begin
			u_host.wr(A_CADD, CAD_PROG[i]);
		end
		u_host.wr(A_CTRL, 16'(1 << F_CAD_GO));
		n = 0;
		while (line_state !== LS_RING && n < 50) begin
			@(posedge mclk);
			n++;
		end
		rd_check("cad_gens", A_CTRL, 16'h000F, 16'h0005);
		rd_check("cad_run", A_STAT, 16'h0001, 16'h0001);
		repeat (MS_SAMPLES * SAMPLE_DIV + 4000) @(posedge mclk);
		check("cad_again", {13'h0000, line_state}, {13'h0000, LS_RING});
		n = 0;
		while (line_state !== 3'h0 && n < 30000) begin
			@(posedge mclk);
			n++;
		end
		check("cad_exit", {13'h0000, line_state}, 16'h0000);
		check("cad_delay", {15'h0000, n > MS_SAMPLES * SAMPLE_DIV - 6000},
			16'h0001);
		rd_check("cad_done", A_STAT, 16'h0001, 16'h0000);
	endtask
	task automatic t_cid();
		int n;
		u_host.cid_fill(CID_DEPTH + 1);
		rd_check("cid_cap", A_STAT, 16'h00FC, 16'(CID_DEPTH << 2));
		u_host.wr(A_CTRL, 16'((1 << F_FRAME) | (1 << F_CID_GO)));
		rd_check("cid_busy", A_STAT, 16'h00FE,
			16'(CID_DEPTH << 2) | 16'h0002);
		// Reset mid-message empties the store so a short load reaches refill
		@(posedge mclk);
		nrst <= 1'b0;
		repeat (2) @(posedge mclk);
		nrst <= 1'b1;
		rd_check("cid_clear", A_STAT, 16'h00FF, 16'h0000);
		u_host.cid_fill(CID_REFILL + 1);
		u_host.wr(A_CADD, 16'h5000);
		u_host.wr(A_CADD, 16'h4006);
		u_host.wr(A_CADD, 16'h0000);
		u_host.wr(A_CTRL, 16'((1 << F_FRAME) | (1 << F_CAD_GO)));
		n = 0;
		while (cid_data_request_event !== 1'b1 && n < BIT_CYCLES + 2000) begin
			@(posedge mclk);
			n++;
		end
		check("cid_cad_run", {13'h0000, line_state},
			{13'h0000, LS_RING});
		check("cid_req", {15'h0000, cid_data_request_event},
			16'h0001);
		check("cid_req_time", {15'h0000, n >= BIT_CYCLES - SAMPLE_DIV
			&& n <= BIT_CYCLES + 4}, 16'h0001);
		@(posedge mclk);
		check("cid_req_pulse", {15'h0000, cid_data_request_event},
			16'h0000);
		rd_check("cid_left", A_STAT, 16'h00FE,
			16'(CID_REFILL << 2) | 16'h0002);
	endtask
	// ----------------------------------------
	// Clock, sequence and watchdog
	// ----------------------------------------
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	initial begin
		nrst = 1'b0;
		repeat (2) @(posedge mclk);
		nrst <= 1'b1;
		t_regs();
		t_bias();
		t_sat();
		t_cad();
		t_cid();
		wrap_up();
	end
	// Expected run is near 88k clocks; this leaves headroom
	initial begin
		repeat (99000) @(posedge mclk);
		num_errors++;
		wrap_up();
	end
endmodule
bind tfg_gen tfg_gen_assertions u_chk (.mclk(mclk), .nrst(nrst),
	.req(req), .reg_rdata(reg_rdata), .sample_out(sample_out),
	.sample_strobe(sample_strobe), .line_state(line_state),
	.cid_data_request_event(cid_data_request_event));
`default_nettype wire
